// ---- src/cpf_crc.sv ----
// Byte-wide step of a bitwise MSB-first check value engine
`timescale 1ns/1ps
module cpf_crc #(
	parameter int W = 16,
	parameter logic [W-1:0] POLY = '0
) (
	input wire logic [W-1:0] i_crc, // Running check value
	input wire logic [7:0] i_byte, // Next input byte
	output logic [W-1:0] o_crc // Value after the byte
);
	// Eight shift-and-xor steps, top bit first
	always_comb begin
		logic [W-1:0] c;
		c = i_crc;
		for (int b = 7; b >= 0; b--) begin
			if (c[W-1] ^ i_byte[b]) begin
				c = {c[W-2:0], 1'b0} ^ POLY;
			end else begin
				c = {c[W-2:0], 1'b0};
			end
		end
		o_crc = c;
	end
endmodule

// ---- src/cpf_host.sv ----
// Host-side packet framer: builds commands and checks responses
//
// Function
// R01: Five-byte header carries all command fields
// R02: Read length gives expected response bytes
// R03: Reads and actions send header only
// R04: Writes add data section, own check
// R05: One register CRC16, several CRC32
// R06: Device auto-increments from start address
// R07: Page skipping rules belong to device
// R08: Software zero-fills gaps, ignores gap data
// R09: Low-page multi reads carry fault prefix
// R10: Length counts check and prefix bytes
// R11: Response registers arrive in order
// R12: Data section at most 62 bytes
// R13: Write lengths four or even eight-62
// R14: Read lengths four or even eight-62
// R15: Illegal length draws negative acknowledge
// R16: Header starts with a leading one
// R17: Address field targets device or broadcast
// R18: Operation bit zero read, one write
// R19: Action commands carry zero length
// R20: Response frame is command frame plus one
// R21: Header check covers first 24 bits
// R22: Data check covers every returned value
// R23: Address five, length six, frame two bits
// R24: CRC16 all-ones start, poly 1021
// R25: CRC32 all-ones start, poly 04c11db7
// R26: Header fields sent MSB first in order
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module cpf_host (
	input wire logic i_mclk, // 40 MHz clock
	input wire logic i_rst, // Synchronous reset, high
	input wire logic [6:0] i_avs_address, // Avalon word address
	input wire logic i_avs_read, // Avalon read
	input wire logic i_avs_write, // Avalon write
	input wire logic [31:0] i_avs_writedata, // Avalon write data
	output logic [31:0] o_avs_readdata, // Avalon read data
	output logic o_avs_waitrequest, // Avalon wait request
	output logic [7:0] o_tx_byte, // Command byte to chain
	output logic o_tx_valid, // Command byte valid
	input wire logic i_tx_ready, // Chain takes byte
	input wire logic [7:0] i_rx_byte, // Response byte
	input wire logic i_rx_valid // Response byte valid
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_TXH = 5'b00010,
		ST_TXD = 5'b00100,
		ST_RXH = 5'b01000,
		ST_RXD = 5'b10000
	} cpf_state_t;

	cpf_state_t state_q, state_d;
	cpf_pkg::cpf_cmd_t cmd_q;
	logic [1:0] frame_q;
	logic [5:0] idx_q;
	logic [15:0] crc16_q;
	logic [31:0] crc32_q;
	logic [15:0] crc16_n;
	logic [31:0] crc32_n;
	logic [23:0] hb_q;
	logic [15:0] fault_q;
	logic [15:0] buf_q [cpf_pkg::BUF_DEPTH];
	logic [7:0] txb_q;
	logic txv_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic done_q, refused_q, hcrc_q, dcrc_q, frerr_q, adderr_q, short_q;
	logic len_legal;

	// Bus handshake and address decode
	wire acc_wr = i_avs_write && !wait_q;
	wire req = i_avs_read || i_avs_write;
	wire idle = state_q == ST_IDLE;
	wire sel_cmd = i_avs_address == cpf_pkg::OFS_CMD;
	wire sel_go = i_avs_address == cpf_pkg::OFS_GO;
	wire sel_frame = i_avs_address == cpf_pkg::OFS_FRAME;
	wire [4:0] buf_idx = i_avs_address[4:0];
	wire sel_buf = i_avs_address[6:5] == cpf_pkg::OFS_BUF_PAGE && buf_idx <= cpf_pkg::BUF_LAST;
	wire go_req = acc_wr && sel_go && i_avs_writedata[0] && idle;
	wire go_ok = go_req && len_legal;
	wire sw_buf_wr = acc_wr && sel_buf && idle;
	// Command kind decode
	wire is_read = cmd_q.kind == cpf_pkg::KIND_READ;
	wire is_write = cmd_q.kind == cpf_pkg::KIND_WRITE;
	wire [8:0] start_addr = {cmd_q.page, cmd_q.reg_a};
	// Received header fields
	cpf_pkg::cpf_rhdr_t rhdr;
	assign rhdr = {hb_q[7:2], hb_q[1:0], hb_q[17], hb_q[16], hb_q[15:14], hb_q[13:8], hb_q[22:18]};
	// R10: data bytes are length less check bytes
	wire [5:0] sec_len = state_q == ST_RXD ? rhdr.len : cmd_q.len;
	wire sec_single = sec_len == cpf_pkg::LEN_SINGLE;
	wire [5:0] ndata = sec_len - (sec_single ? cpf_pkg::CRC16_BYTES : cpf_pkg::CRC32_BYTES);
	// R09: fault prefix on low-page multi reads
	wire prefix = is_read && !sec_single && start_addr <= cpf_pkg::FAULT_LAST_ADDR;
	wire in_data = idx_q < ndata;
	wire sec_last = idx_q == sec_len - 6'h01;
	wire [5:0] crc_pos = idx_q - ndata;
	wire [5:0] word_pos = idx_q - (prefix ? cpf_pkg::FAULT_BYTES : 6'h00);
	wire [4:0] word_idx = word_pos[5:1];
	// R26: header bytes, MSB first in field order
	// R16: leading one opens the header
	// R18: operation bit from access kind
	// R23: five-bit address, six-bit length, two-bit frame
	wire op_bit = is_write ? cpf_pkg::RW_WRITE : cpf_pkg::RW_READ;
	wire [7:0] hdr0 = {cpf_pkg::LEAD_ONE, cmd_q.dev, op_bit, cmd_q.page[2]};
	wire [7:0] hdr1 = {cmd_q.page[1:0], cmd_q.reg_a};
	wire [7:0] hdr2 = {cmd_q.len, frame_q};
	wire [7:0] hdr_crc_byte = idx_q[0] ? crc16_q[15:8] : crc16_q[7:0];
	// R05: single register closes with CRC16, else CRC32
	wire [1:0] cp = crc_pos[1:0];
	wire [7:0] crc32_byte = cp == 2'h0 ? crc32_q[31:24] : cp == 2'h1 ? crc32_q[23:16] :
		cp == 2'h2 ? crc32_q[15:8] : crc32_q[7:0];
	wire [7:0] crc16_byte = cp[0] ? crc16_q[7:0] : crc16_q[15:8];
	wire [7:0] sec_crc_byte = sec_single ? crc16_byte : crc32_byte;
	// Byte chosen for the next command slot
	wire [7:0] hdr_tx = idx_q == 6'h00 ? hdr0 : idx_q == 6'h01 ? hdr1 : idx_q == 6'h02 ? hdr2 : hdr_crc_byte;
	// R08: gap words go out as software left them
	wire [7:0] dat_word = idx_q[0] ? buf_q[word_idx][7:0] : buf_q[word_idx][15:8];
	wire [7:0] dat_tx = in_data ? dat_word : sec_crc_byte;
	wire [7:0] tx_mux = state_q == ST_TXH ? hdr_tx : dat_tx;
	// Link handshakes
	wire tx_hs = txv_q && i_tx_ready;
	// R16: a response starts only at a byte with a leading one
	wire rx_take = i_rx_valid && (state_q == ST_RXD || (state_q == ST_RXH && (idx_q != 6'h00 || i_rx_byte[7])));
	wire hdr_body = idx_q < cpf_pkg::HDR_CRC_FIRST;
	wire hdr_sec = state_q == ST_TXH || state_q == ST_RXH;
	wire rx_side = state_q == ST_RXH || state_q == ST_RXD;
	wire step = tx_hs || rx_take;
	// R21: header check runs over the first three bytes only
	// R22: data check runs over every data byte returned
	wire crc_feed = step && (hdr_sec ? hdr_body : in_data);
	wire [7:0] crc_byte = rx_side ? i_rx_byte : txb_q;
	wire crc_bad = rx_take && i_rx_byte != (state_q == ST_RXH ? hdr_crc_byte : sec_crc_byte);

	// Response routing
	wire in_prefix = prefix && idx_q < cpf_pkg::FAULT_BYTES;
	wire rx_data = rx_take && state_q == ST_RXD && in_data;
	wire rx_buf_wr = rx_data && !in_prefix;
	wire [1:0] frame_exp = frame_q + 2'h1;
	wire rx_hdr_end = rx_take && state_q == ST_RXH && idx_q == cpf_pkg::HDR_LAST;
	wire rlen_ok = rhdr.len >= cpf_pkg::LEN_SINGLE;
	wire finish = !idle && state_d == ST_IDLE;

	// R24: header engine
	cpf_crc #(
		.W(16),
		.POLY(cpf_pkg::CRC16_POLY)
	) u_crc16 (
		.i_crc(crc16_q),
		.i_byte(crc_byte),
		.o_crc(crc16_n)
	);

	// R25: wide data engine
	cpf_crc #(
		.W(32),
		.POLY(cpf_pkg::CRC32_POLY)
	) u_crc32 (
		.i_crc(crc32_q),
		.i_byte(crc_byte),
		.o_crc(crc32_n)
	);

	// R13: length legality for the latched command
	cpf_len_chk u_len (
		.i_kind(cmd_q.kind),
		.i_len(cmd_q.len),
		.o_legal(len_legal)
	);

	// Sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (go_ok) begin
					state_d = ST_TXH;
				end
			end
			ST_TXH: begin
				// R01: five header bytes, then onward
				// R03: reads and actions end after the header
				// R04: writes continue with a data section
				if (tx_hs && idx_q == cpf_pkg::HDR_LAST) begin
					state_d = is_write ? ST_TXD : (is_read ? ST_RXH : ST_IDLE);
				end
			end
			ST_TXD: begin
				if (tx_hs && sec_last) begin
					state_d = ST_RXH;
				end
			end
			ST_RXH: begin
				// R02: a read waits for its data section
				if (rx_hdr_end) begin
					state_d = (is_read && rlen_ok) ? ST_RXD : ST_IDLE;
				end
			end
			ST_RXD: begin
				// R11: section ends when the byte count is met
				if (rx_take && sec_last) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// State and byte index
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			idx_q <= 6'h00;
		end else begin
			state_q <= state_d;
			idx_q <= (state_d != state_q) ? 6'h00 : (step ? idx_q + 6'h01 : idx_q);
		end
	end

	// Check engines restart at each section
	always_ff @(posedge i_mclk) begin
		if (i_rst || state_d != state_q) begin
			crc16_q <= cpf_pkg::CRC16_INIT;
			crc32_q <= cpf_pkg::CRC32_INIT;
		end else if (crc_feed) begin
			crc16_q <= crc16_n;
			crc32_q <= crc32_n;
		end
	end

	// Command byte register, one slot per two cycles
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			txv_q <= 1'b0;
			txb_q <= 8'h00;
		end else if (tx_hs) begin
			txv_q <= 1'b0;
		end else if ((state_q == ST_TXH || state_q == ST_TXD) && !txv_q) begin
			txv_q <= 1'b1;
			txb_q <= tx_mux;
		end
	end

	// Command, frame and response header capture
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmd_q <= '0;
			frame_q <= 2'h0;
			hb_q <= 24'h000000;
		end else begin
			if (acc_wr && sel_cmd && idle) begin
				cmd_q <= i_avs_writedata[21:0];
			end
			if (acc_wr && sel_frame && idle) begin
				frame_q <= i_avs_writedata[1:0];
			end else if (finish) begin
				frame_q <= frame_exp;
			end
			if (rx_take && state_q == ST_RXH && hdr_body) begin
				hb_q <= {hb_q[15:0], i_rx_byte};
			end
		end
	end

	// Fault summary word from the read prefix
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			fault_q <= 16'h0000;
		end else if (rx_data && in_prefix) begin
			fault_q <= idx_q[0] ? {fault_q[15:8], i_rx_byte} : {i_rx_byte, fault_q[7:0]};
		end
	end

	// Status flags, cleared by each start; a start with an illegal length sets done and refused
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			{done_q, refused_q, hcrc_q, dcrc_q, frerr_q, adderr_q, short_q} <= 7'h00;
		end else if (go_req) begin
			// R15: an illegal length is never sent
			{done_q, refused_q, hcrc_q, dcrc_q, frerr_q, adderr_q, short_q} <= {!len_legal, !len_legal, 5'h00};
		end else begin
			done_q <= done_q || finish;
			hcrc_q <= hcrc_q || (state_q == ST_RXH && !hdr_body && crc_bad);
			dcrc_q <= dcrc_q || (state_q == ST_RXD && !in_data && crc_bad);
			// R20: response frame must be ours plus one
			frerr_q <= frerr_q || (rx_hdr_end && rhdr.frame != frame_exp);
			// R17: response must name the addressed device
			adderr_q <= adderr_q || (rx_hdr_end && cmd_q.dev != cpf_pkg::DEV_BCAST && rhdr.dev != cmd_q.dev);
			short_q <= short_q || (rx_hdr_end && is_read && !rlen_ok);
		end
	end

	// Data buffer, software fills and responses land here
	for (genvar gi = 0; gi < cpf_pkg::BUF_DEPTH; gi++) begin : g_buf
		wire sw_hit = sw_buf_wr && buf_idx == 5'(gi);
		wire rx_hit = rx_buf_wr && word_idx == 5'(gi);
		always_ff @(posedge i_mclk) begin
			if (i_rst) begin
				buf_q[gi] <= 16'h0000;
			end else if (sw_hit) begin
				buf_q[gi] <= i_avs_writedata[15:0];
			end else if (rx_hit && !word_pos[0]) begin
				buf_q[gi][15:8] <= i_rx_byte;
			end else if (rx_hit) begin
				buf_q[gi][7:0] <= i_rx_byte;
			end
		end
	end

	// Read mux for the bus
	wire [7:0] status = {short_q, adderr_q, frerr_q, dcrc_q, hcrc_q, refused_q, done_q, !idle};
	wire [31:0] rd_mux = sel_cmd ? {10'h000, cmd_q} :
		i_avs_address == cpf_pkg::OFS_STATUS ? {24'h000000, status} :
		i_avs_address == cpf_pkg::OFS_RHDR ? {9'h000, rhdr} :
		i_avs_address == cpf_pkg::OFS_FAULT ? {16'h0000, fault_q} :
		sel_frame ? {30'h0, frame_q} :
		sel_buf ? {16'h0000, buf_q[buf_idx]} : 32'h00000000;

	// One wait cycle per access, read data caught then
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			wait_q <= !(req && wait_q);
			if (req && wait_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata = rdata_q;
	assign o_tx_byte = txb_q;
	assign o_tx_valid = txv_q;
endmodule

// ---- src/cpf_len_chk.sv ----
// Legal payload length check for each access kind
`timescale 1ns/1ps
module cpf_len_chk (
	input wire logic [1:0] i_kind, // Access kind
	input wire logic [5:0] i_len, // Payload length in bytes
	output logic o_legal // Length allowed for that kind
);
	logic multi_ok;
	logic data_ok;

	// R12: data section capped at maximum
	// R13: even lengths from eight up to the maximum, or single
	assign multi_ok = !i_len[0] && i_len >= cpf_pkg::LEN_MULTI_MIN && i_len <= cpf_pkg::LEN_MAX;
	assign data_ok = i_len == cpf_pkg::LEN_SINGLE || multi_ok;

	// R14: reads take the same set, eight included
	// R19: action commands carry zero length
	always_comb begin
		unique case (i_kind)
			cpf_pkg::KIND_READ: o_legal = data_ok;
			cpf_pkg::KIND_WRITE: o_legal = data_ok;
			cpf_pkg::KIND_ACTION: o_legal = i_len == cpf_pkg::LEN_ACTION;
			default: o_legal = 1'b0;
		endcase
	end
endmodule

// ---- src/cpf_pkg.sv ----
// Constants, field layouts and carrier types of the chain packet framer host
package cpf_pkg;
	// Register word offsets on the Avalon-MM slave
	localparam logic [6:0] OFS_CMD = 7'h00;
	localparam logic [6:0] OFS_GO = 7'h01;
	localparam logic [6:0] OFS_STATUS = 7'h02;
	localparam logic [6:0] OFS_RHDR = 7'h03;
	localparam logic [6:0] OFS_FAULT = 7'h04;
	localparam logic [6:0] OFS_FRAME = 7'h05;
	localparam logic [1:0] OFS_BUF_PAGE = 2'h1; // Buffer at word offsets 7'h20..7'h3c
	localparam int BUF_DEPTH = 29;
	localparam logic [4:0] BUF_LAST = 5'h1c;

	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_HCRC = 3;
	localparam int ST_DCRC = 4;
	localparam int ST_FRAME = 5;
	localparam int ST_ADDR = 6;
	localparam int ST_SHORT = 7;

	// Header layout and protocol figures
	localparam logic LEAD_ONE = 1'b1;
	localparam logic RW_READ = 1'b0;
	localparam logic RW_WRITE = 1'b1;
	localparam logic [5:0] HDR_LAST = 6'h04;
	localparam logic [5:0] HDR_CRC_FIRST = 6'h03;
	localparam logic [4:0] DEV_BCAST = 5'h1f;
	localparam logic [8:0] FAULT_LAST_ADDR = 9'h07f;
	localparam logic [5:0] LEN_ACTION = 6'h00;
	localparam logic [5:0] LEN_SINGLE = 6'h04;
	localparam logic [5:0] LEN_MULTI_MIN = 6'h08;
	localparam logic [5:0] LEN_MAX = 6'h3e;
	localparam logic [5:0] CRC16_BYTES = 6'h02;
	localparam logic [5:0] CRC32_BYTES = 6'h04;
	localparam logic [5:0] FAULT_BYTES = 6'h02;

	// Check value engines
	localparam logic [15:0] CRC16_INIT = 16'hffff;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [31:0] CRC32_INIT = 32'hffffffff;
	localparam logic [31:0] CRC32_POLY = 32'h04c11db7;

	// Access kinds held in the command register
	localparam logic [1:0] KIND_READ = 2'h0;
	localparam logic [1:0] KIND_WRITE = 2'h1;
	localparam logic [1:0] KIND_ACTION = 2'h2;

	// Command register fields, device address in the low bits
	typedef struct packed {
		logic [5:0] len;
		logic [5:0] reg_a;
		logic [2:0] page;
		logic [1:0] kind;
		logic [4:0] dev;
	} cpf_cmd_t;

	// Received response header fields
	typedef struct packed {
		logic [5:0] len;
		logic [1:0] frame;
		logic rw;
		logic [2:0] page;
		logic [5:0] reg_a;
		logic [4:0] dev;
	} cpf_rhdr_t;
endpackage

// ---- tb/cpf_dev_mdl.sv ----
// Behavioural stacked device that answers the host framer
`timescale 1ns/1ps
module cpf_dev_mdl (
	input wire logic i_mclk, // Clock
	input wire logic i_slow, // Stall and space replies
	input wire logic [7:0] i_tx_byte, // Command byte
	input wire logic i_tx_valid, // Command byte valid
	output logic o_tx_ready, // Command byte taken
	output logic [7:0] o_rx_byte, // Reply byte
	output logic o_rx_valid // Reply byte strobe
);
	logic [7:0] h [5];
	logic [7:0] r [72];
	logic [31:0] c;
	logic [15:0] wd;
	logic [5:0] ln;
	logic w32, f;
	int n, k, seed = 19293;
	// Ready stalls at random in slow mode
	always @(posedge i_mclk) o_tx_ready <= i_slow ? 1'($random(seed)) : 1'b1;
	task automatic take(output logic [7:0] b);
		do @(posedge i_mclk);
		while (!(i_tx_valid && o_tx_ready));
		b = i_tx_byte;
	endtask
	// Reply bytes, idle data inverted between strobes
	task automatic send(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			if (i_slow) begin
				o_rx_valid <= 1'b0;
				o_rx_byte <= ~o_rx_byte;
				repeat (2) @(posedge i_mclk);
			end
			o_rx_byte <= r[i];
			o_rx_valid <= 1'b1;
			@(posedge i_mclk);
		end
		o_rx_valid <= 1'b0;
		o_rx_byte <= ~o_rx_byte;
	endtask
	// reply header with own address and frame plus one
	initial begin
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		forever begin
			for (int i = 0; i < 5; i++) take(h[i]);
			ln = h[2][7:2];
			if (h[0][1] || ln != 6'h00) begin
				// write data and its check are consumed
				if (h[0][1]) for (int i = 0; i < ln; i++) take(wd[7:0]);
				r[0] = {1'b1, h[0][6:2] == cpf_pkg::DEV_BCAST ? cpf_tb_pkg::OWN_DEV : h[0][6:2], h[0][1:0]};
				r[1] = h[1];
				r[2] = {h[0][1] ? 6'h00 : ln, h[2][1:0] + 2'h1};
				c = {16'h0000, cpf_pkg::CRC16_INIT};
				for (int i = 0; i < 3; i++) c = cpf_tb_pkg::crc_b(c, r[i], 1'b0);
				r[3] = c[15:8];
				r[4] = c[7:0];
				n = 5;
				// read data counts every slot, prefix on low multi reads
				if (!h[0][1]) begin
					w32 = ln != 6'h04;
					f = w32 && {h[0][0], h[1]} <= cpf_pkg::FAULT_LAST_ADDR;
					c = w32 ? cpf_pkg::CRC32_INIT : {16'h0000, cpf_pkg::CRC16_INIT};
					for (k = 0; n < ln + (w32 ? 1 : 3); k++) begin
						wd = (f && k == 0) ? cpf_tb_pkg::FAULT_W : 16'h5a00 + 16'(k - f);
						r[n] = wd[15:8];
						r[n + 1] = wd[7:0];
						c = cpf_tb_pkg::crc_b(cpf_tb_pkg::crc_b(c, wd[15:8], w32), wd[7:0], w32);
						n += 2;
					end
					for (k = w32 ? 3 : 1; k >= 0; k--) begin
						r[n] = c[8 * k +: 8];
						n++;
					end
				end
				send(n);
			end
		end
	end
endmodule

// ---- tb/cpf_host_sva.sv ----
// Concurrent checks on the host framer's bus and command link
`timescale 1ns/1ps
module cpf_host_sva (
	input wire logic i_mclk, // Clock
	input wire logic i_rst, // Reset
	input wire logic [6:0] i_avs_address, // Word address
	input wire logic i_avs_read, // Read
	input wire logic i_avs_write, // Write
	input wire logic [31:0] i_avs_writedata, // Write data
	input wire logic [31:0] o_avs_readdata, // Read data
	input wire logic o_avs_waitrequest, // Wait
	input wire logic [7:0] o_tx_byte, // Command byte
	input wire logic o_tx_valid, // Byte valid
	input wire logic i_tx_ready, // Byte taken
	input wire logic [7:0] i_rx_byte, // Reply byte
	input wire logic i_rx_valid // Reply strobe
);
	cpf_pkg::cpf_cmd_t cmd_q;
	logic [6:0] idx_q;
	wire acc_w = i_avs_write && !o_avs_waitrequest;
	wire go_w = acc_w && i_avs_address == cpf_pkg::OFS_GO && i_avs_writedata[0];
	wire cmd_w = acc_w && i_avs_address == cpf_pkg::OFS_CMD;
	wire take_w = o_tx_valid && i_tx_ready;
	// Last command and bytes taken since start
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmd_q <= '0;
			idx_q <= '0;
		end else begin
			if (cmd_w) cmd_q <= i_avs_writedata[21:0];
			if (go_w) idx_q <= '0;
			else if (take_w) idx_q <= idx_q + 7'h01;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	property p_wait_one;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer late");
	property p_wait_pulse;
		!o_avs_waitrequest |=> o_avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
	property p_tx_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("byte dropped before taken");
	property p_tx_gap;
		take_w |=> !o_tx_valid;
	endproperty
	a_tx_gap: assert property (p_tx_gap) else $error("no gap after byte");
	property p_lead;
		o_tx_valid && idx_q == 7'h00 |-> o_tx_byte == {1'b1, cmd_q.dev, cmd_q.kind == cpf_pkg::KIND_WRITE, cmd_q.page[2]};
	endproperty
	a_lead: assert property (p_lead) else $error("bad first header byte");
	property p_addr;
		o_tx_valid && idx_q == 7'h01 |-> o_tx_byte == {cmd_q.page[1:0], cmd_q.reg_a};
	endproperty
	a_addr: assert property (p_addr) else $error("bad second header byte");
	property p_len;
		o_tx_valid && idx_q == 7'h02 |-> o_tx_byte[7:2] == cmd_q.len;
	endproperty
	a_len: assert property (p_len) else $error("bad length field");
	property p_hdr_only;
		o_tx_valid && cmd_q.kind != cpf_pkg::KIND_WRITE |-> idx_q < 7'h05;
	endproperty
	a_hdr_only: assert property (p_hdr_only) else $error("data after read header");
endmodule
bind cpf_host cpf_host_sva i_cpf_host_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_tx_byte(o_tx_byte),
	.o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .i_rx_byte(i_rx_byte), .i_rx_valid(i_rx_valid));

// ---- tb/cpf_tb_pkg.sv ----
// Check value step and reply constants shared by bench and device model
package cpf_tb_pkg;
	localparam logic [15:0] FAULT_W = 16'hf00d;
	localparam logic [4:0] OWN_DEV = 5'h07;
	// One byte into a 16 or 32 bit engine, MSB first
	function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] b, logic w32);
		logic [31:0] p;
		logic t;
		p = w32 ? cpf_pkg::CRC32_POLY : {16'h0000, cpf_pkg::CRC16_POLY};
		for (int i = 7; i >= 0; i--) begin
			t = (w32 ? c[31] : c[15]) ^ b[i];
			c = {c[30:0], 1'b0} ^ (t ? p : 32'h00000000);
		end
		return w32 ? c : {16'h0000, c[15:0]};
	endfunction
endpackage

// ---- tb/tb_top.sv ----
// Self-checking bench for the chain packet framer host
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, slow = 1'b0;
	logic [6:0] adr = 7'h00;
	logic [31:0] wd = 32'h00000000, rdat, rv;
	logic wreq, tx_v, tx_r, rx_v;
	logic [7:0] tx_b, rx_b;
	logic [7:0] exp_q [$];
	logic [7:0] bad [9] = '{8'h02, 8'h06, 8'h0b, 8'h3f, 8'h46, 8'h45, 8'h7f, 8'h84, 8'hc0};
	int bad_count = 0, n_tests = 0, seed = 19293;
	initial forever #12.5 mclk = ~mclk;
	cpf_host i_cpf_host (.i_mclk(mclk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_tx_byte(tx_b),
		.o_tx_valid(tx_v), .i_tx_ready(tx_r), .i_rx_byte(rx_b), .i_rx_valid(rx_v));
	cpf_dev_mdl i_cpf_dev_mdl (.i_mclk(mclk), .i_slow(slow), .i_tx_byte(tx_b), .i_tx_valid(tx_v),
		.o_tx_ready(tx_r), .o_rx_byte(rx_b), .o_rx_valid(rx_v));
	task automatic test_done;
		if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	// One Avalon access, held until wait is seen low
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		int t;
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (wreq !== 1'b0 && t < 20);
		if (wreq !== 1'b0) begin
			bad_count++;
			test_done;
		end
		rv = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Each command byte taken is matched against the oldest note
	always @(posedge mclk) if (tx_v === 1'b1 && tx_r === 1'b1) chk(tx_b, exp_q.size() ? exp_q.pop_front() : 8'hxx);
	task automatic run(input logic [1:0] kd, input logic [4:0] dv, input logic [2:0] pg, input logic [5:0] ra, ln,
		input logic ok);
		logic [7:0] d [$];
		logic [31:0] c, e;
		logic [15:0] w;
		logic [1:0] fr;
		logic w32, f;
		int nw, t;
		fr = 2'($random(seed));
		slow <= 1'($random(seed));
		w32 = ln != 6'h04;
		f = w32 && kd == cpf_pkg::KIND_READ && {pg, ra} <= cpf_pkg::FAULT_LAST_ADDR;
		nw = (int'(ln) - (w32 ? 4 : 2) - (f ? 2 : 0)) / 2;
		// write data and its own check
		c = w32 ? cpf_pkg::CRC32_INIT : 32'h0000ffff;
		for (int i = 0; kd == cpf_pkg::KIND_WRITE && i < nw; i++) begin
			w = 16'($random(seed));
			bus(1, 7'h20 + 7'(i), {16'h0000, w});
			d.push_back(w[15:8]);
			d.push_back(w[7:0]);
			c = cpf_tb_pkg::crc_b(cpf_tb_pkg::crc_b(c, w[15:8], w32), w[7:0], w32);
		end
		for (int k = w32 ? 3 : 1; kd == cpf_pkg::KIND_WRITE && k >= 0; k--) d.push_back(c[8 * k +: 8]);
		bus(1, cpf_pkg::OFS_FRAME, {30'h0, fr});
		bus(1, cpf_pkg::OFS_CMD, {10'h000, ln, ra, pg, kd, dv});
		if (ok) begin
			exp_q = '{{1'b1, dv, kd == cpf_pkg::KIND_WRITE, pg[2]}, {pg[1:0], ra}, {ln, fr}};
			c = 32'h0000ffff;
			for (int i = 0; i < 3; i++) c = cpf_tb_pkg::crc_b(c, exp_q[i], 1'b0);
			exp_q = {exp_q, c[15:8], c[7:0], d};
		end
		bus(1, cpf_pkg::OFS_GO, 32'h00000001);
		t = 0;
		do begin
			bus(0, cpf_pkg::OFS_STATUS, 32'h0);
			t++;
		end while (rv[cpf_pkg::ST_DONE] !== 1'b1 && t < 500);
		chk(rv[7:0], ok ? 8'h02 : 8'h06);
		chk(exp_q.size(), 0);
		if (rv[1] !== 1'b1) test_done;
		e = {9'h000, kd == cpf_pkg::KIND_WRITE ? 6'h00 : ln, fr + 2'h1, kd == cpf_pkg::KIND_WRITE, pg, ra, dv};
		if (dv == cpf_pkg::DEV_BCAST) e[4:0] = cpf_tb_pkg::OWN_DEV;
		if (ok && kd != cpf_pkg::KIND_ACTION) begin
			bus(0, cpf_pkg::OFS_RHDR, 32'h0);
			chk(rv, e);
		end
		// registers land in order, prefix apart
		for (int i = 0; ok && kd == cpf_pkg::KIND_READ && i < nw; i++) begin
			bus(0, 7'h20 + 7'(i), 32'h0);
			chk(rv, 32'h5a00 + i);
		end
		if (ok && f) begin
			bus(0, cpf_pkg::OFS_FAULT, 32'h0);
			chk(rv, {16'h0000, cpf_tb_pkg::FAULT_W});
		end
		bus(0, cpf_pkg::OFS_FRAME, 32'h0);
		chk(rv, {30'h0, ok ? fr + 2'h1 : fr});
	endtask
	// Reset, register defaults, then every kind of transfer
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		bus(0, cpf_pkg::OFS_STATUS, 32'h0);
		chk(rv, 32'h0);
		bus(1, 7'h10, 32'hffffffff);
		bus(0, 7'h10, 32'h0);
		chk(rv, 32'h0);
		run(cpf_pkg::KIND_READ, 5'h05, 3'h2, 6'h07, 6'h04, 1'b1);
		run(cpf_pkg::KIND_READ, 5'h02, 3'h1, 6'h10, 6'h04, 1'b1);
		run(cpf_pkg::KIND_READ, 5'h04, 3'h1, 6'h20, 6'h0a, 1'b1);
		run(cpf_pkg::KIND_READ, 5'h04, 3'h2, 6'h01, 6'h08, 1'b1);
		run(cpf_pkg::KIND_READ, 5'h1f, 3'h1, 6'h3e, 6'h3e, 1'b1);
		run(cpf_pkg::KIND_WRITE, 5'h03, 3'h1, 6'h05, 6'h04, 1'b1);
		run(cpf_pkg::KIND_WRITE, 5'h1f, 3'h2, 6'h00, 6'h3e, 1'b1);
		run(cpf_pkg::KIND_WRITE, 5'h0a, 3'h2, 6'h02, 6'h08, 1'b1);
		run(cpf_pkg::KIND_ACTION, 5'h06, 3'h3, 6'h11, 6'h00, 1'b1);
		foreach (bad[i]) run(bad[i][7:6], 5'h01, 3'h1, 6'h00, bad[i][5:0], 1'b0);
		test_done;
	end
endmodule
